// file: common/fwp_defines.svh
// offsets, field positions, mode codes, clock rate and timings in microseconds for fwp
`ifndef FWP_DEFINES_SVH
`define FWP_DEFINES_SVH
`define FWP_A_STATUS1      4'h0
`define FWP_A_CONFIG1      4'h1
`define FWP_A_GUARD_MODE   4'h2
`define FWP_A_LOCK         4'h3
`define FWP_A_SECT_SEL     4'h4
`define FWP_A_PPB_RD       4'h5
`define FWP_A_DYB_RD       4'h6
`define FWP_A_OTP_LOCK     4'h7
`define FWP_A_PASS_LO      4'h8
`define FWP_A_PASS_HI      4'h9
`define FWP_A_CMD          4'hA
`define FWP_A_ARG          4'hB
`define FWP_A_TGT_SECT     4'hC
`define FWP_A_GATE         4'hD
`define FWP_A_LEARN        4'hE
`define FWP_SR_WEL         1
`define FWP_SR_WIP         0
`define FWP_SR_PERR        6
`define FWP_SR_STATUS_WRITE_DISABLE        7
`define FWP_CR_FREEZE      0
`define FWP_CR_TBPROT      5
`define FWP_OTP_LOCK0_ADDR 8'h10
`define FWP_MODE_UNSEL     2'h3
`define FWP_MODE_PERSIST   2'h2
`define FWP_MODE_PASSWORD  2'h1
`define FWP_MODE_ILLEGAL   2'h0
`define FWP_CLK_MHZ        125
`define FWP_PAGE_PROG_US   1
`define FWP_SECT_ERASE_US  2
`define FWP_UNLOCK_US      100
`endif

// file: common/fwp_pkg.sv
// types shared by the flash write protection block
package fwp_pkg;
  typedef enum logic [3:0] {
    FWP_CMD_NONE, FWP_CMD_WRITE_ENABLE_CMD, FWP_CMD_WRITE_DISABLE_CMD, FWP_CMD_WRR, FWP_CMD_WRITE_ANY_REGISTER_CMD,
    FWP_CMD_OTP_PROGRAM_CMD, FWP_CMD_GUARD_REGISTER_PROGRAM_CMD, FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD, FWP_CMD_PERSISTENT_BIT_ERASE_CMD, FWP_CMD_LOCK_CLEAR_CMD,
    FWP_CMD_DYNAMIC_BIT_WRITE_CMD, FWP_CMD_PASSWORD_PROGRAM_CMD, FWP_CMD_LEARNING_PATTERN_PROGRAM_CMD, FWP_CMD_UNLOCK,
    FWP_CMD_SWRST, FWP_CMD_ERASE
  } fwp_cmd_e;
  typedef enum logic [1:0] {FWP_IDLE, FWP_BUSY, FWP_UNLOCK_WAIT} fwp_state_e;
endpackage : fwp_pkg

// file: src/fwp_core.sv
// write/erase protection logic of a serial nor flash
`timescale 1ns/1ps
`include "fwp_defines.svh"

module fwp_core #(
  parameter int SECTORS     = 256,
  parameter int SECT_W      = 8,
  parameter int UNLOCK_CYC  = `FWP_UNLOCK_US * `FWP_CLK_MHZ,
  parameter int ERASE_CYC   = `FWP_SECT_ERASE_US * `FWP_CLK_MHZ,
  parameter int PAGE_CYC    = `FWP_PAGE_PROG_US * `FWP_CLK_MHZ
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // pins
  input  wire logic              wp_n,
  input  wire logic              hw_reset_n,
  // register port
  input  wire logic [3:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  // array gate
  output logic                   sector_blocked
);
  localparam int CW = 20;

  logic [1:0]        wp_s_q, hr_s_q;
  logic [7:0]        status_q;
  logic [7:0]        config_q;
  logic [1:0]        mode_q;
  logic              lock_q;
  logic [SECTORS-1:0] ppb_q, dyb_q;
  logic [31:0]       otp_lock_q;
  logic [63:0]       pass_q;
  logic [7:0]        learn_q;
  logic              learn_set_q;
  logic [31:0]       arg_q;
  logic [SECT_W-1:0] tgt_q;
  logic [CW-1:0]     cnt_q;
  logic [31:0]       rdata_q;
  logic              blk_q;
  fwp_pkg::fwp_state_e state_q;

  logic              hwr;
  logic              write_enable_latch, write_in_progress, frozen, selected, srlock;
  logic              cmd_go, cmd_ok, perr_set;
  logic [CW-1:0]     busy_len;
  fwp_pkg::fwp_cmd_e cmd;

  assign hwr      = rst | ~hr_s_q[1];
  assign write_enable_latch      = status_q[`FWP_SR_WEL];
  assign write_in_progress      = (state_q != fwp_pkg::FWP_IDLE);
  assign frozen   = config_q[`FWP_CR_FREEZE];
  assign selected = (mode_q != `FWP_MODE_UNSEL);
  assign srlock   = ~wp_s_q[1] & status_q[`FWP_SR_STATUS_WRITE_DISABLE];
  assign cmd      = fwp_pkg::fwp_cmd_e'(wdata[3:0]);
  assign cmd_go   = wr && addr == `FWP_A_CMD && !write_in_progress;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // block protect range check on the sector index
  function automatic logic bp_hit(input logic [2:0] bp, input logic tb,
                                  input logic [SECT_W-1:0] s);
    logic [SECT_W:0] span;
    span = '0;
    if (bp == 3'h7) span = (SECT_W+1)'(SECTORS);
    else if (bp != 3'h0)
      span = (SECT_W+1)'(SECTORS >> (7 - int'(bp)));
    if (tb) bp_hit = {1'b0, s} < span;
    else    bp_hit = {1'b0, s} >= (SECT_W+1)'(SECTORS) - span;
  endfunction : bp_hit

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'((n < 1) ? 1 : n);
  endfunction : cyc

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  always_comb begin
    cmd_ok   = 1'b0;
    perr_set = 1'b0;
    busy_len = cyc(PAGE_CYC);
    if (cmd_go && write_enable_latch) begin
      unique case (cmd)
        fwp_pkg::FWP_CMD_WRR, fwp_pkg::FWP_CMD_WRITE_ANY_REGISTER_CMD: begin
          cmd_ok = !srlock && !frozen;
        end
        fwp_pkg::FWP_CMD_OTP_PROGRAM_CMD: begin
          // region zero locks guarded by lsb of first lock byte
          cmd_ok   = !frozen && !(otp_lock_q[0] && arg_q[10:6] == 5'h00
                     && arg_q[5:0] >= 6'(`FWP_OTP_LOCK0_ADDR))
                     && !otp_lock_q[arg_q[10:6]];
          perr_set = !cmd_ok;
        end
        fwp_pkg::FWP_CMD_GUARD_REGISTER_PROGRAM_CMD: begin
          cmd_ok   = !selected && arg_q[1:0] != `FWP_MODE_ILLEGAL;
          perr_set = !cmd_ok;
        end
        fwp_pkg::FWP_CMD_PASSWORD_PROGRAM_CMD, fwp_pkg::FWP_CMD_LEARNING_PATTERN_PROGRAM_CMD: begin
          cmd_ok   = !selected;
          perr_set = selected;
        end
        fwp_pkg::FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD: cmd_ok = lock_q;
        fwp_pkg::FWP_CMD_PERSISTENT_BIT_ERASE_CMD: begin
          cmd_ok   = lock_q;
          busy_len = cyc(ERASE_CYC);
        end
        fwp_pkg::FWP_CMD_ERASE: cmd_ok = !blk_q;
        default: cmd_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_s_q <= 2'h3;
      hr_s_q <= 2'h3;
    end else begin
      wp_s_q <= {wp_s_q[0], wp_n};
      hr_s_q <= {hr_s_q[0], hw_reset_n};
    end
  end

  // ----------------------------------------------------------------
  // busy sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (hwr) begin
      state_q         <= fwp_pkg::FWP_IDLE;
      cnt_q           <= '0;
    end else begin
      unique case (state_q)
        fwp_pkg::FWP_IDLE: begin
          if (cmd_ok) begin
            state_q <= fwp_pkg::FWP_BUSY;
            cnt_q   <= busy_len;
          end else if (cmd_go && cmd == fwp_pkg::FWP_CMD_UNLOCK &&
                       mode_q == `FWP_MODE_PASSWORD) begin
            // wrong password holds busy to slow brute force
            if ({wdata[31:4], arg_q} != pass_q[59:0] ||
                wdata[31:28] != pass_q[63:60]) begin
              state_q <= fwp_pkg::FWP_UNLOCK_WAIT;
              cnt_q   <= cyc(UNLOCK_CYC);
            end
          end
        end
        default: begin
          if (cnt_q <= CW'(1)) state_q <= fwp_pkg::FWP_IDLE;
          cnt_q <= cnt_q - CW'(1);
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status and configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (hwr) begin
      status_q <= 8'h00;
      config_q <= 8'h00;
    end else begin
      if (cmd_go && cmd == fwp_pkg::FWP_CMD_WRITE_ENABLE_CMD)
        status_q[`FWP_SR_WEL] <= 1'b1;
      if (cmd_go && cmd != fwp_pkg::FWP_CMD_WRITE_ENABLE_CMD &&
          cmd != fwp_pkg::FWP_CMD_UNLOCK && cmd != fwp_pkg::FWP_CMD_DYNAMIC_BIT_WRITE_CMD)
        status_q[`FWP_SR_WEL] <= 1'b0;
      if (cmd_ok && (cmd == fwp_pkg::FWP_CMD_WRR ||
                     cmd == fwp_pkg::FWP_CMD_WRITE_ANY_REGISTER_CMD)) begin
        status_q[`FWP_SR_STATUS_WRITE_DISABLE] <= arg_q[7];
        status_q[4:2]          <= arg_q[4:2];
        config_q[`FWP_CR_FREEZE] <= frozen | arg_q[8];
        if (!selected) config_q[5:2] <= arg_q[13:10];
      end
      if (perr_set) status_q[`FWP_SR_PERR] <= 1'b1;
      else if (cmd_go && cmd == fwp_pkg::FWP_CMD_WRITE_DISABLE_CMD)
        status_q[`FWP_SR_PERR] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // advanced sector guard
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q      <= `FWP_MODE_UNSEL;
      ppb_q       <= '1;
      pass_q      <= '1;
      otp_lock_q  <= '0;
      learn_q     <= 8'h00;
      learn_set_q <= 1'b0;
    end else if (cmd_ok) begin
      unique case (cmd)
        fwp_pkg::FWP_CMD_GUARD_REGISTER_PROGRAM_CMD:  mode_q <= arg_q[1:0];
        fwp_pkg::FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD:  ppb_q[tgt_q] <= 1'b0;
        fwp_pkg::FWP_CMD_PERSISTENT_BIT_ERASE_CMD:  ppb_q <= '1;
        fwp_pkg::FWP_CMD_PASSWORD_PROGRAM_CMD: pass_q <= pass_q & {wdata, arg_q};
        fwp_pkg::FWP_CMD_OTP_PROGRAM_CMD:
          if (arg_q[10:0] == 11'(`FWP_OTP_LOCK0_ADDR))
            otp_lock_q <= otp_lock_q | wdata;
        fwp_pkg::FWP_CMD_LEARNING_PATTERN_PROGRAM_CMD: begin
          learn_q     <= arg_q[7:0];
          learn_set_q <= 1'b1;
        end
        default: learn_q <= learn_q;
      endcase
    end
  end

  // lock bit ignores software reset entirely
  always_ff @(posedge clk) begin
    if (hwr) begin
      lock_q <= (mode_q != `FWP_MODE_PASSWORD);
      dyb_q  <= '1;
    end else begin
      if (cmd_go && cmd == fwp_pkg::FWP_CMD_LOCK_CLEAR_CMD)
        lock_q <= 1'b0;
      else if (cmd_go && cmd == fwp_pkg::FWP_CMD_UNLOCK &&
               mode_q == `FWP_MODE_PASSWORD && !write_in_progress &&
               {wdata[31:4], arg_q} == pass_q[59:0] &&
               wdata[31:28] == pass_q[63:60])
        lock_q <= 1'b1;
      if (cmd_go && cmd == fwp_pkg::FWP_CMD_DYNAMIC_BIT_WRITE_CMD)
        dyb_q[tgt_q] <= arg_q[0];
    end
  end

  // ----------------------------------------------------------------
  // operands, gate and read back
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      arg_q <= 32'h0000_0000;
      tgt_q <= '0;
    end else if (wr) begin
      if (addr == `FWP_A_ARG)      arg_q <= wdata;
      if (addr == `FWP_A_TGT_SECT) tgt_q <= wdata[SECT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) blk_q <= 1'b0;
    else blk_q <= bp_hit(status_q[4:2], config_q[`FWP_CR_TBPROT], tgt_q) |
                  ~ppb_q[tgt_q] | ~dyb_q[tgt_q];
  end
  assign sector_blocked = blk_q;

  always_ff @(posedge clk) begin
    if (rst) rdata_q <= 32'h0000_0000;
    else if (rd) begin
      unique case (addr)
        `FWP_A_STATUS1:    rdata_q <= {24'h0, status_q[7:1], write_in_progress};
        `FWP_A_CONFIG1:    rdata_q <= {24'h0, config_q};
        `FWP_A_GUARD_MODE: rdata_q <= {29'h0, mode_q, 1'b1};
        `FWP_A_LOCK:       rdata_q <= {31'h0, lock_q};
        `FWP_A_PPB_RD:     rdata_q <= {31'h0, ppb_q[tgt_q]};
        `FWP_A_DYB_RD:     rdata_q <= {31'h0, dyb_q[tgt_q]};
        `FWP_A_OTP_LOCK:   rdata_q <= otp_lock_q;
        `FWP_A_GATE:       rdata_q <= {31'h0, blk_q};
        `FWP_A_LEARN:      rdata_q <= {23'h0, learn_set_q, learn_q};
        default:           rdata_q <= 32'h0000_0000;
      endcase
    end else rdata_q <= 32'h0000_0000;
  end
  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_write_enable_cmd;
    cmd_go && cmd == fwp_pkg::FWP_CMD_WRITE_ENABLE_CMD;
  endsequence
  wel_set_a: assert property (@(posedge clk) disable iff (hwr)
    s_write_enable_cmd |=> write_enable_latch) else $error("latch not set by write enable");
  wel_ignore_a: assert property (@(posedge clk) disable iff (hwr)
    cmd_go && !write_enable_latch |-> !cmd_ok) else $error("command ran without latch");
  wel_clear_a: assert property (@(posedge clk) disable iff (hwr)
    cmd_ok |=> !write_enable_latch) else $error("latch not cleared");
  ppb_locked_a: assert property (@(posedge clk) disable iff (hwr)
    !lock_q |=> $stable(ppb_q)) else $error("ppb changed while locked");
  illegal_mode_a: assert property (@(posedge clk) disable iff (hwr)
    cmd_go && cmd == fwp_pkg::FWP_CMD_GUARD_REGISTER_PROGRAM_CMD && write_enable_latch &&
    arg_q[1:0] == 2'h0 |=> status_q[6] && $stable(mode_q))
    else $error("illegal mode accepted");
  mode_fixed_a: assert property (@(posedge clk) disable iff (rst)
    selected |=> $stable(mode_q) && $stable(pass_q))
    else $error("selected mode changed");
  busy_shown_a: assert property (@(posedge clk) disable iff (hwr)
    cmd_ok |=> write_in_progress [*1]) else $error("busy not shown");
  sector_or_a: assert property (@(posedge clk) disable iff (hwr)
    !ppb_q[tgt_q] && $stable(tgt_q) |=> sector_blocked)
    else $error("ppb zero not blocking");
  freeze_a: assert property (@(posedge clk) disable iff (hwr)
    frozen |=> $stable(status_q[4:2]) && $stable(otp_lock_q))
    else $error("frozen bits changed");
  wp_guard_a: assert property (@(posedge clk) disable iff (hwr)
    cmd_go && srlock |=> $stable(config_q) && $stable(status_q[4:2]))
    else $error("status written under write protect");
  lock_sticky_a: assert property (@(posedge clk) disable iff (hwr)
    mode_q != `FWP_MODE_PASSWORD && !lock_q |=> !lock_q)
    else $error("lock set again by command");
  sequence s_unlock;
    cmd_go && cmd == fwp_pkg::FWP_CMD_UNLOCK && mode_q == `FWP_MODE_PASSWORD;
  endsequence
  unlock_hold_a: assert property (@(posedge clk) disable iff (hwr)
    s_unlock ##1 !lock_q |-> write_in_progress)
    else $error("wrong password not held busy");
  dyb_write_a: assert property (@(posedge clk) disable iff (hwr)
    cmd_go && cmd == fwp_pkg::FWP_CMD_DYNAMIC_BIT_WRITE_CMD |=> dyb_q[tgt_q] == arg_q[0])
    else $error("dynamic bit not written");
endmodule : fwp_core

// file: verif/fwp_host_model.sv
// host controller model driving the register port of the protection block
`timescale 1ns/1ps
`include "fwp_defines.svh"

module fwp_host_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [3:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  initial begin
    addr  = 4'h0;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;  // released data never shows the old value
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // latch first, argument before the command code
  task automatic cmd(input fwp_pkg::fwp_cmd_e c, input logic [31:0] arg,
                     input logic [27:0] hi);
    wr_reg(`FWP_A_CMD, {28'h0, fwp_pkg::FWP_CMD_WRITE_ENABLE_CMD});
    wr_reg(`FWP_A_ARG, arg);
    wr_reg(`FWP_A_CMD, {hi, c});
  endtask : cmd
endmodule : fwp_host_model

// file: verif/tb_flash_write_protection_logic.sv
// self-checking bench for the flash write protection block
`timescale 1ns/1ps
`include "fwp_defines.svh"

module tb_flash_write_protection_logic;
  localparam logic [3:0] ST = `FWP_A_STATUS1;
  localparam logic [3:0] CF = `FWP_A_CONFIG1;
  localparam logic [3:0] MD = `FWP_A_GUARD_MODE;
  localparam logic [3:0] LK = `FWP_A_LOCK;
  localparam logic [3:0] PB = `FWP_A_PPB_RD;
  localparam logic [3:0] DB = `FWP_A_DYB_RD;
  localparam logic [3:0] TG = `FWP_A_TGT_SECT;
  localparam logic [31:0] PW_LO = 32'h1357_9BDF;
  localparam logic [31:0] PW_HI = 32'hAA12_345B;  // low nibble is the code
  logic        clk, rst, wp_n, hw_reset_n, wr, rd, sector_blocked;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, d;
  int          mismatches, checks_done, cnt;

  // short counts keep the run brief
  fwp_core #(.PAGE_CYC(8), .ERASE_CYC(12), .UNLOCK_CYC(20)) dut_u (
    .clk(clk), .rst(rst), .wp_n(wp_n), .hw_reset_n(hw_reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sector_blocked(sector_blocked));
  fwp_host_model host_u (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rdc(input logic [3:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    host_u.rd_reg(a, d);
    check(d & m, e);
  endtask : rdc

  task automatic blk(input logic [7:0] s, input logic e);
    host_u.wr_reg(TG, {24'h0, s});
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, sector_blocked}, {31'h0, e});
  endtask : blk

  // bounded poll of the busy flag
  task automatic idle();
    int n;
    n = 0;
    do begin
      host_u.rd_reg(ST, d);
      n++;
    end while (d[0] !== 1'b0 && n < 100);
    if (d[0] !== 1'b0) check(d, 32'h0);
  endtask : idle

  task automatic cm(input fwp_pkg::fwp_cmd_e c, input logic [31:0] a);
    host_u.cmd(c, a, 28'h0);
    idle();
  endtask : cm

  task automatic hwr();
    @(posedge clk);
    hw_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : hwr

  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    #400000;
    mismatches++;
    end_sim();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    hw_reset_n = 1'b1;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(ST, 32'h2, 32'h0);
    rdc(MD, 32'h7, 32'h7);
    rdc(LK, 32'h1, 32'h1);
    blk(8'h05, 1'b0);
    rdc(PB, 32'h1, 32'h1);
    rdc(DB, 32'h1, 32'h1);
    host_u.wr_reg(`FWP_A_CMD, {28'h0, fwp_pkg::FWP_CMD_WRITE_ENABLE_CMD});
    rdc(ST, 32'h2, 32'h2);
    host_u.wr_reg(`FWP_A_CMD, {28'h0, fwp_pkg::FWP_CMD_WRITE_DISABLE_CMD});
    rdc(ST, 32'h2, 32'h0);
    host_u.wr_reg(`FWP_A_ARG, 32'h5);
    host_u.wr_reg(`FWP_A_CMD, {28'h0, fwp_pkg::FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD});
    rdc(PB, 32'h1, 32'h1);
    host_u.cmd(fwp_pkg::FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD, 32'h5, 28'h0);
    rdc(ST, 32'h3, 32'h1);
    idle();
    rdc(PB, 32'h1, 32'h0);
    blk(8'h05, 1'b1);
    blk(8'h06, 1'b0);
    host_u.cmd(fwp_pkg::FWP_CMD_PERSISTENT_BIT_ERASE_CMD, 32'h0, 28'h0);
    rdc(ST, 32'h1, 32'h1);
    idle();
    blk(8'h05, 1'b0);
    cm(fwp_pkg::FWP_CMD_DYNAMIC_BIT_WRITE_CMD, 32'h0);
    rdc(DB, 32'h1, 32'h0);
    blk(8'h05, 1'b1);
    cm(fwp_pkg::FWP_CMD_DYNAMIC_BIT_WRITE_CMD, 32'h1);
    blk(8'h05, 1'b0);
    // block protect codes 1 to 7, top anchored, both sides of the range edge where the range is partial
    for (int n = 1; n < 8; n++) begin
      cnt = 256 >> (7 - n);
      cm(fwp_pkg::FWP_CMD_WRR, 32'(n) << 2);
      rdc(ST, 32'h1C, 32'(n) << 2);
      blk(8'(256 - cnt), 1'b1);
      if (cnt < 256) blk(8'(255 - cnt), 1'b0);
    end
    cm(fwp_pkg::FWP_CMD_WRR, 32'h2004);
    rdc(CF, 32'h20, 32'h20);
    blk(8'h03, 1'b1);
    blk(8'hC8, 1'b0);
    cm(fwp_pkg::FWP_CMD_DYNAMIC_BIT_WRITE_CMD, 32'h0);
    blk(8'hC8, 1'b1);
    cm(fwp_pkg::FWP_CMD_WRR, 32'h84);
    @(posedge clk);
    wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    cm(fwp_pkg::FWP_CMD_WRR, 32'h1C);
    rdc(ST, 32'h9C, 32'h84);
    @(posedge clk);
    wp_n <= 1'b1;
    repeat (4) @(posedge clk);
    cm(fwp_pkg::FWP_CMD_WRR, 32'h104);
    rdc(ST, 32'h9C, 32'h04);
    rdc(CF, 32'h1, 32'h1);
    cm(fwp_pkg::FWP_CMD_WRR, 32'h18);
    rdc(ST, 32'h1C, 32'h04);
    cm(fwp_pkg::FWP_CMD_OTP_PROGRAM_CMD, 32'h20);
    rdc(ST, 32'h40, 32'h40);
    // power cycle lifts the freeze
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(CF, 32'h1, 32'h0);
    blk(8'h05, 1'b0);
    cm(fwp_pkg::FWP_CMD_LOCK_CLEAR_CMD, 32'h0);
    rdc(LK, 32'h1, 32'h0);
    cm(fwp_pkg::FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD, 32'h5);
    rdc(PB, 32'h1, 32'h1);
    host_u.wr_reg(`FWP_A_CMD, {28'h0, fwp_pkg::FWP_CMD_SWRST});
    rdc(LK, 32'h1, 32'h0);
    hwr();
    rdc(LK, 32'h1, 32'h1);
    cm(fwp_pkg::FWP_CMD_GUARD_REGISTER_PROGRAM_CMD, 32'h0);
    rdc(MD, 32'h7, 32'h7);
    rdc(ST, 32'h40, 32'h40);
    host_u.wr_reg(`FWP_A_CMD, {28'h0, fwp_pkg::FWP_CMD_WRITE_DISABLE_CMD});
    rdc(ST, 32'h40, 32'h0);
    host_u.cmd(fwp_pkg::FWP_CMD_PASSWORD_PROGRAM_CMD, PW_LO, PW_HI[31:4]);
    idle();
    host_u.cmd(fwp_pkg::FWP_CMD_GUARD_REGISTER_PROGRAM_CMD, 32'h1, 28'h0);
    rdc(ST, 32'h1, 32'h1);
    idle();
    rdc(MD, 32'h7, 32'h3);
    cm(fwp_pkg::FWP_CMD_PASSWORD_PROGRAM_CMD, 32'h0);
    rdc(ST, 32'h40, 32'h40);
    cm(fwp_pkg::FWP_CMD_WRR, 32'h2000);
    rdc(CF, 32'h20, 32'h0);
    hwr();
    rdc(LK, 32'h1, 32'h0);
    host_u.cmd(fwp_pkg::FWP_CMD_UNLOCK, PW_LO ^ 32'h1, PW_HI[27:0]);
    rdc(ST, 32'h1, 32'h1);
    idle();
    rdc(LK, 32'h1, 32'h0);
    host_u.cmd(fwp_pkg::FWP_CMD_UNLOCK, PW_LO, PW_HI[27:0]);
    rdc(ST, 32'h1, 32'h0);
    rdc(LK, 32'h1, 32'h1);
    host_u.wr_reg(TG, 32'h5);
    cm(fwp_pkg::FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD, 32'h5);
    rdc(PB, 32'h1, 32'h0);
    // fresh part, persistent mode chosen for good
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cm(fwp_pkg::FWP_CMD_GUARD_REGISTER_PROGRAM_CMD, 32'h2);
    rdc(MD, 32'h7, 32'h5);
    cm(fwp_pkg::FWP_CMD_PASSWORD_PROGRAM_CMD, 32'h0);
    rdc(ST, 32'h40, 32'h40);
    hwr();
    rdc(LK, 32'h1, 32'h1);
    end_sim();
  end
endmodule : tb_flash_write_protection_logic
